// *** logic/usc_params.svh ***
// Offsets, field positions, reset values and counts of the serial status and control block
// Assumes inclusion by bare name; byte addresses on a 32-bit classic Wishbone slave
// Behaviour
// R01: tx select 10 pulses irq when a move to the shifter empties the buffer.
// R02: tx select 01 pulses irq once the last character left and nothing remains.
// R03: tx select 00 pulses irq on every move from buffer to shifter.
// R04: Software never writes 11 to the tx select field; it is reserved.
// R05: Without infrared, line idles at 0 when inverted, at 1 otherwise.
// R06: With infrared, encoded line idles at 1 when inverted, at 0 otherwise.
// R07: A pending break request sends start, twelve zero bits, then stop.
// R08: Hardware clears the break request once the break has gone out.
// R09: With transmit enabled the serial port drives the transmit pin.
// R10: Disabling transmit aborts the frame, empties the buffer, releases the pin.
// R11: Buffer-full flag reads 1 when full, 0 while a character fits.
// R12: Shifter-empty flag is 1 only with shifter and buffer empty; resets to 1.
// R13: rx select 11 pulses irq on the transfer that makes four characters.
// R14: rx select 10 pulses irq on the transfer that makes three characters.
// R15: rx select 0x pulses irq on every transfer into the receive buffer.
// R16: Overrun sets on arrival into a full buffer; only software clears it.
`ifndef USC_PARAMS_SVH
`define USC_PARAMS_SVH

`define USC_ADR_STA     5'h00
`define USC_ADR_TXD     5'h04
`define USC_ADR_RXD     5'h08
`define USC_ADR_CTRL    5'h0c

`define USC_B_TXSEL_HI  15
`define USC_B_INV       14
`define USC_B_TXSEL_LO  13
`define USC_B_BRK       11
`define USC_B_TXEN      10
`define USC_B_BFULL     9
`define USC_B_TEMPTY    8
`define USC_B_RXSEL_HI  7
`define USC_B_RXSEL_LO  6
`define USC_B_ADET      5
`define USC_B_RIDLE     4
`define USC_B_PERR      3
`define USC_B_FERR      2
`define USC_B_OVR       1
`define USC_B_RXAV      0
`define USC_B_INFRARED_ENCODE_ENABLE      16

`define USC_STA_RST     16'h0110
`define USC_DIV_RST     16'h0015
`define USC_DATA_BITS   4'h8
`define USC_BRK_BITS    4'hc

`endif

// *** logic/usc_pkg.sv ***
// Types shared by the serial status and control block
// Assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package usc_pkg;
  // Gray order along idle, start, data, stop
  typedef enum logic [1:0] {
    USC_IDLE  = 2'b00,
    USC_START = 2'b01,
    USC_DATA  = 2'b11,
    USC_STOP  = 2'b10
  } usc_bit_e;
  typedef logic [7:0] usc_char_t;
endpackage : usc_pkg
`default_nettype wire

// *** logic/usc_fifo.sv ***
// Small FIFO with valid and ready on both sides, flush and fill count
// Assumes one clock, synchronous active-high reset and a freezing clock enable
`timescale 1ns/1ps
`default_nettype none
module usc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 2,
  parameter int AW    = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
  // Clock and control
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  input  wire logic          flush_i,
  // Filling side
  input  wire logic          in_valid_i,
  output logic               in_ready_o,
  input  wire logic [W-1:0]  in_data_i,
  // Draining side
  output logic               out_valid_o,
  input  wire logic          out_ready_i,
  output logic [W-1:0]       out_data_o,
  output logic [AW:0]        count_o
);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign in_ready_o  = cnt_q != (AW+1)'(DEPTH);
  assign out_valid_o = cnt_q != '0;
  assign out_data_o  = mem_q[rp_q];
  assign count_o     = cnt_q;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && flush_i)) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (ce_i) begin
      if (push) begin
        wp_q <= wrap_inc(wp_q);
      end
      if (pop) begin
        rp_q <= wrap_inc(rp_q);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage needs no reset; count guards every read
  always_ff @(posedge clk_i) begin
    if (ce_i && push && !flush_i) begin
      mem_q[wp_q] <= in_data_i;
    end
  end
endmodule : usc_fifo
`default_nettype wire

// *** logic/usc_bit_timer.sv ***
// Bit-period down counter: reload on load_i, tick when it reaches zero
// Assumes one clock, synchronous active-high reset and a freezing clock enable
`timescale 1ns/1ps
`default_nettype none
module usc_bit_timer #(
  parameter int W = 16
) (
  // Clock and control
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  input  wire logic          load_i,
  input  wire logic          half_i,
  input  wire logic [W-1:0]  div_i,
  // Timing
  output logic               tick_o,
  output logic [W-1:0]       cnt_o
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (ce_i) begin
      if (load_i) begin
        cnt_q <= half_i ? (div_i >> 1) : div_i;
      end else if (cnt_q == '0) begin
        cnt_q <= div_i;
      end else begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  assign tick_o = ce_i && !load_i && (cnt_q == '0);
  assign cnt_o  = cnt_q;
endmodule : usc_bit_timer
`default_nettype wire

// *** logic/usc_status_ctrl.sv ***
// Serial port status and control: Wishbone registers, transmitter, receiver
// Assumes synchronous serial input and a host interrupt controller on the irq pulses
//
// Design decisions made here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "usc_params.svh"
module usc_status_ctrl #(
  parameter int DIV_W    = 16,
  parameter int TX_DEPTH = 2,
  parameter int RX_DEPTH = 4
) (
  // Clock, reset, enable
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  // Wishbone slave
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [4:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic [31:0]       wb_dat_o,
  output logic              wb_ack_o,
  // Serial line
  output logic              serial_tx_o,
  output logic              serial_tx_oe_o,
  input  wire logic         serial_rx_i,
  // Interrupt pulses
  output logic              tx_irq_o,
  output logic              rx_irq_o
);
  import usc_pkg::*;

  localparam int TX_AW = (TX_DEPTH > 1) ? $clog2(TX_DEPTH) : 1;
  localparam int RX_AW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;

  // Control and status state
  logic [1:0]       tx_irq_select_q;
  logic             tx_polarity_invert_q;
  logic             send_break_request_q;
  logic             tx_enable_bit_q;
  logic [1:0]       rx_irq_select_q;
  logic             addr_detect_q;
  logic             rx_overrun_flag_q;
  logic             rx_frame_err_q;
  logic             infrared_encode_enable_q;
  logic [DIV_W-1:0] div_q;
  logic             ack_q;
  logic [31:0]      rdat_q;
  logic             txo_q;
  logic             txoe_q;
  logic             tx_irq_q;
  logic             rx_irq_q;

  // Bus decode
  logic             req;
  logic             wr;
  logic             rd;
  logic [4:0]       adr;
  logic             sta_wr_hi;
  logic             sta_wr_lo;

  // Transmit path
  usc_bit_e         tx_st_q;
  logic [11:0]      tx_sh_q;
  logic [3:0]       tx_n_q;
  logic             tx_brk_q;
  logic             tx_lvl;
  logic             tx_take;
  logic             tx_start_brk;
  logic             tx_done;
  logic             tx_tick;
  logic [DIV_W-1:0] tx_cnt;
  logic             ir_phase;
  logic             txf_push;
  logic             txf_in_ready;
  logic             txf_valid;
  usc_char_t        txf_data;
  logic [TX_AW:0]   txf_count;
  logic             tx_shifter_empty_flag;
  logic             tx_buffer_full_flag;

  // Receive path
  usc_bit_e         rx_st_q;
  usc_char_t        rx_shift_register_q;
  logic [3:0]       rx_n_q;
  logic             rx_tick;
  logic             rx_load;
  logic             rx_done;
  logic             rx_push;
  logic             rxf_in_ready;
  logic             rxf_valid;
  logic             rxf_pop;
  usc_char_t        rxf_data;
  logic [RX_AW:0]   rxf_count;
  logic [RX_AW:0]   rx_after;

  assign adr       = {wb_adr_i[4:2], 2'b00};
  assign req       = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr        = req && wb_we_i;
  assign rd        = req && !wb_we_i;
  assign sta_wr_hi = wr && (adr == `USC_ADR_STA) && wb_sel_i[1];
  assign sta_wr_lo = wr && (adr == `USC_ADR_STA) && wb_sel_i[0];
  assign txf_push  = wr && (adr == `USC_ADR_TXD) && wb_sel_i[0];
  assign rxf_pop   = rd && (adr == `USC_ADR_RXD) && rxf_valid;

  // R11 buffer full flag
  assign tx_buffer_full_flag   = !txf_in_ready;
  // R12 both stages empty
  assign tx_shifter_empty_flag = (tx_st_q == USC_IDLE) && !txf_valid;

  // Bus answer: one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= '0;
    end else if (ce_i) begin
      ack_q  <= req;
      rdat_q <= '0;
      if (rd) begin
        case (adr)
          `USC_ADR_STA: begin
            rdat_q[`USC_B_TXSEL_HI] <= tx_irq_select_q[1];
            rdat_q[`USC_B_INV]      <= tx_polarity_invert_q;
            rdat_q[`USC_B_TXSEL_LO] <= tx_irq_select_q[0];
            rdat_q[`USC_B_BRK]      <= send_break_request_q;
            rdat_q[`USC_B_TXEN]     <= tx_enable_bit_q;
            rdat_q[`USC_B_BFULL]    <= tx_buffer_full_flag;
            rdat_q[`USC_B_TEMPTY]   <= tx_shifter_empty_flag;
            rdat_q[`USC_B_RXSEL_HI] <= rx_irq_select_q[1];
            rdat_q[`USC_B_RXSEL_LO] <= rx_irq_select_q[0];
            rdat_q[`USC_B_ADET]     <= addr_detect_q;
            rdat_q[`USC_B_RIDLE]    <= rx_st_q == USC_IDLE;
            rdat_q[`USC_B_FERR]     <= rx_frame_err_q;
            rdat_q[`USC_B_OVR]      <= rx_overrun_flag_q;
            rdat_q[`USC_B_RXAV]     <= rxf_valid;
          end
          `USC_ADR_RXD: rdat_q[7:0] <= rxf_valid ? rxf_data : 8'h00;
          `USC_ADR_CTRL: begin
            rdat_q[DIV_W-1:0]    <= div_q;
            rdat_q[`USC_B_INFRARED_ENCODE_ENABLE]  <= infrared_encode_enable_q;
          end
          default: rdat_q <= '0;
        endcase
      end
    end
  end

  // Software written control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_irq_select_q          <= 2'b00;
      tx_polarity_invert_q     <= 1'b0;
      tx_enable_bit_q          <= 1'b0;
      rx_irq_select_q          <= 2'b00;
      addr_detect_q            <= 1'b0;
      infrared_encode_enable_q <= 1'b0;
      div_q                    <= DIV_W'(`USC_DIV_RST);
    end else if (ce_i) begin
      if (sta_wr_hi) begin
        // R04 reserved code stored as written
        tx_irq_select_q      <= {wb_dat_i[`USC_B_TXSEL_HI], wb_dat_i[`USC_B_TXSEL_LO]};
        tx_polarity_invert_q <= wb_dat_i[`USC_B_INV];
        tx_enable_bit_q      <= wb_dat_i[`USC_B_TXEN];
      end
      if (sta_wr_lo) begin
        rx_irq_select_q <= wb_dat_i[`USC_B_RXSEL_HI:`USC_B_RXSEL_LO];
        addr_detect_q   <= wb_dat_i[`USC_B_ADET];
      end
      if (wr && (adr == `USC_ADR_CTRL)) begin
        if (wb_sel_i[0]) begin
          div_q <= wb_dat_i[DIV_W-1:0];
        end
        if (wb_sel_i[2]) begin
          infrared_encode_enable_q <= wb_dat_i[`USC_B_INFRARED_ENCODE_ENABLE];
        end
      end
    end
  end

  // R08 self clearing break request; a software set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      send_break_request_q <= 1'b0;
    end else if (ce_i) begin
      if (sta_wr_hi) begin
        send_break_request_q <= wb_dat_i[`USC_B_BRK];
      end else if (tx_done && tx_brk_q) begin
        send_break_request_q <= 1'b0;
      end
    end
  end

  // R16 overrun flag; arrival wins over a clearing write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_overrun_flag_q <= 1'b0;
    end else if (ce_i) begin
      if (rx_done && !rxf_in_ready) begin
        rx_overrun_flag_q <= 1'b1;
      end else if (sta_wr_lo && !wb_dat_i[`USC_B_OVR]) begin
        rx_overrun_flag_q <= 1'b0;
      end
    end
  end

  // Transmit buffer; a write to a full buffer is dropped
  usc_fifo #(.W(8), .DEPTH(TX_DEPTH)) u_tx_buf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .flush_i     (!tx_enable_bit_q),
    .in_valid_i  (txf_push),
    .in_ready_o  (txf_in_ready),
    .in_data_i   (wb_dat_i[7:0]),
    .out_valid_o (txf_valid),
    .out_ready_i (tx_take),
    .out_data_o  (txf_data),
    .count_o     (txf_count)
  );

  usc_bit_timer #(.W(DIV_W)) u_tx_timer (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .load_i (tx_take || tx_start_brk),
    .half_i (1'b0),
    .div_i  (div_q),
    .tick_o (tx_tick),
    .cnt_o  (tx_cnt)
  );

  // R07 a pending break goes before queued data
  assign tx_start_brk = tx_enable_bit_q && (tx_st_q == USC_IDLE) && send_break_request_q;
  assign tx_take      = tx_enable_bit_q && (tx_st_q == USC_IDLE) && !send_break_request_q
                        && txf_valid;
  assign tx_done      = tx_tick && (tx_st_q == USC_STOP);

  // R10 disable aborts the frame in flight
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_st_q  <= USC_IDLE;
      tx_sh_q  <= '0;
      tx_n_q   <= '0;
      tx_brk_q <= 1'b0;
    end else if (ce_i) begin
      if (!tx_enable_bit_q) begin
        tx_st_q <= USC_IDLE;
      end else begin
        case (tx_st_q)
          USC_IDLE: begin
            if (tx_take || tx_start_brk) begin
              tx_st_q  <= USC_START;
              tx_sh_q  <= tx_take ? {4'h0, txf_data} : 12'h000;
              // R07 twelve zero bits
              tx_n_q   <= tx_take ? `USC_DATA_BITS : `USC_BRK_BITS;
              tx_brk_q <= !tx_take;
            end
          end
          USC_START: if (tx_tick) begin
            tx_st_q <= USC_DATA;
          end
          USC_DATA: if (tx_tick) begin
            tx_sh_q <= tx_sh_q >> 1;
            tx_n_q  <= tx_n_q - 4'h1;
            if (tx_n_q == 4'h1) begin
              tx_st_q <= USC_STOP;
            end
          end
          USC_STOP: if (tx_tick) begin
            tx_st_q <= USC_IDLE;
          end
          default: tx_st_q <= USC_IDLE;
        endcase
      end
    end
  end

  assign tx_lvl   = (tx_st_q == USC_START) ? 1'b0 :
                    (tx_st_q == USC_DATA)  ? tx_sh_q[0] : 1'b1;
  // Pulse in the first quarter of a zero bit; narrower than a bit, so the far end
  // must time its decode from the pulse edge
  assign ir_phase = tx_cnt > (div_q - (div_q >> 2));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txo_q  <= 1'b1;
      txoe_q <= 1'b0;
    end else if (ce_i) begin
      // R09 pin owned while enabled
      txoe_q <= tx_enable_bit_q;
      if (infrared_encode_enable_q) begin
        // R06 encoded idle follows the invert bit
        txo_q <= (!tx_lvl && ir_phase) ? !tx_polarity_invert_q : tx_polarity_invert_q;
      end else begin
        // R05 plain idle is the inverse of the invert bit
        txo_q <= tx_lvl ^ tx_polarity_invert_q;
      end
    end
  end

  // R01 R02 R03 transmit event select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_irq_q <= 1'b0;
    end else if (ce_i) begin
      case (tx_irq_select_q)
        2'b00: tx_irq_q <= tx_take;
        2'b10: tx_irq_q <= tx_take && (txf_count == (TX_AW+1)'(1)) && !txf_push;
        2'b01: tx_irq_q <= tx_done && !txf_valid;
        default: tx_irq_q <= 1'b0;
      endcase
    end
  end

  // Receive buffer
  usc_fifo #(.W(8), .DEPTH(RX_DEPTH)) u_rx_buf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .flush_i     (1'b0),
    .in_valid_i  (rx_done),
    .in_ready_o  (rxf_in_ready),
    .in_data_i   (rx_shift_register_q),
    .out_valid_o (rxf_valid),
    .out_ready_i (rxf_pop),
    .out_data_o  (rxf_data),
    .count_o     (rxf_count)
  );

  usc_bit_timer #(.W(DIV_W)) u_rx_timer (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .load_i (rx_load),
    .half_i (1'b1),
    .div_i  (div_q),
    .tick_o (rx_tick),
    .cnt_o  ()
  );

  assign rx_load  = (rx_st_q == USC_IDLE) && !serial_rx_i;
  assign rx_done  = rx_tick && (rx_st_q == USC_STOP);
  assign rx_push  = rx_done && rxf_in_ready;
  assign rx_after = rxf_count + (RX_AW+1)'(1) - (RX_AW+1)'(rxf_pop);

  // Half-period load centres every sample; a short low pulse is dropped at start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_st_q             <= USC_IDLE;
      rx_shift_register_q <= '0;
      rx_n_q              <= '0;
      rx_frame_err_q      <= 1'b0;
    end else if (ce_i) begin
      case (rx_st_q)
        USC_IDLE: if (rx_load) begin
          rx_st_q <= USC_START;
        end
        USC_START: if (rx_tick) begin
          rx_st_q <= serial_rx_i ? USC_IDLE : USC_DATA;
          rx_n_q  <= `USC_DATA_BITS;
        end
        USC_DATA: if (rx_tick) begin
          rx_shift_register_q <= {serial_rx_i, rx_shift_register_q[7:1]};
          rx_n_q              <= rx_n_q - 4'h1;
          if (rx_n_q == 4'h1) begin
            rx_st_q <= USC_STOP;
          end
        end
        USC_STOP: if (rx_tick) begin
          rx_st_q        <= USC_IDLE;
          rx_frame_err_q <= !serial_rx_i;
        end
        default: rx_st_q <= USC_IDLE;
      endcase
    end
  end

  // R13 R14 R15 receive event select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_irq_q <= 1'b0;
    end else if (ce_i) begin
      case (rx_irq_select_q)
        2'b11: rx_irq_q <= rx_push && (rx_after == (RX_AW+1)'(RX_DEPTH));
        2'b10: rx_irq_q <= rx_push && (rx_after == (RX_AW+1)'(RX_DEPTH - 1));
        default: rx_irq_q <= rx_push;
      endcase
    end
  end

  assign wb_dat_o       = rdat_q;
  assign wb_ack_o       = ack_q;
  assign serial_tx_o    = txo_q;
  assign serial_tx_oe_o = txoe_q;
  assign tx_irq_o       = tx_irq_q;
  assign rx_irq_o       = rx_irq_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_brk_go;
    ce_i && tx_start_brk ##1 (tx_st_q == USC_START);
  endsequence

  a_tx_every_move: assert property ( // R03
    ce_i && tx_irq_select_q == 2'b00 && tx_take |=> tx_irq_o ##1 (!$past(ce_i) || !tx_irq_o))
    else $error("tx irq missing on move");
  a_tx_empty_move: assert property ( // R01
    ce_i && tx_irq_select_q == 2'b10 && tx_take |=> tx_irq_o == ($past(txf_count) == 1
      && !$past(txf_push)))
    else $error("tx irq wrong on emptying move");
  a_tx_all_done: assert property ( // R02
    $past(ce_i) && $past(tx_irq_select_q) == 2'b01 && tx_irq_o |-> $past(tx_st_q) == USC_STOP
      && !$past(txf_valid))
    else $error("tx irq before transmit done");
  a_plain_idle: assert property ( // R05
    ce_i && !infrared_encode_enable_q && tx_st_q == USC_IDLE |=> serial_tx_o == !$past(
      tx_polarity_invert_q))
    else $error("plain idle level wrong");
  a_ir_idle: assert property ( // R06
    ce_i && infrared_encode_enable_q && tx_st_q == USC_IDLE |=> serial_tx_o == $past(
      tx_polarity_invert_q))
    else $error("encoded idle level wrong");
  a_brk_frame: assert property ( // R07
    s_brk_go |-> tx_n_q == `USC_BRK_BITS && tx_brk_q && tx_sh_q == 12'h000)
    else $error("break frame not twelve zeros");
  a_brk_clear: assert property ( // R08
    ce_i && tx_done && tx_brk_q && !sta_wr_hi |=> !send_break_request_q)
    else $error("break request not cleared");
  a_tx_owns_pin: assert property ( // R09
    ce_i && tx_enable_bit_q |=> serial_tx_oe_o)
    else $error("pin not driven while enabled");
  a_tx_abort: assert property ( // R10
    ce_i && !tx_enable_bit_q |=> !serial_tx_oe_o && tx_st_q == USC_IDLE && txf_count == 0)
    else $error("disable did not abort");
  a_full_read: assert property ( // R11
    ce_i && rd && adr == `USC_ADR_STA |=> wb_ack_o && wb_dat_o[`USC_B_BFULL] == (
      $past(txf_count) == TX_DEPTH))
    else $error("full flag misread");
  a_empty_read: assert property ( // R12
    ce_i && rd && adr == `USC_ADR_STA |=> wb_dat_o[`USC_B_TEMPTY] == ($past(tx_st_q) ==
      USC_IDLE && $past(txf_count) == 0))
    else $error("shifter empty misread");
  a_rx_four: assert property ( // R13
    ce_i && rx_irq_select_q == 2'b11 && rx_done && rxf_count == 3 && !rxf_pop |=> rx_irq_o)
    else $error("rx irq missing at four");
  a_rx_three: assert property ( // R14
    ce_i && rx_irq_select_q == 2'b10 && rx_push |=> rx_irq_o == ($past(rx_after) == 3))
    else $error("rx irq wrong at three");
  a_rx_each: assert property ( // R15
    ce_i && !rx_irq_select_q[1] |=> rx_irq_o == $past(rx_push))
    else $error("rx irq wrong per character");
  a_ovr_sticky: assert property ( // R16
    ce_i && rx_done && rxf_count == RX_DEPTH && !rxf_pop |=> rx_overrun_flag_q
      ##1 (rx_overrun_flag_q || $past(sta_wr_lo)))
    else $error("overrun not held");
endmodule : usc_status_ctrl
`default_nettype wire

// *** verification/usc_serial_peer.sv ***
// Remote serial peer: sends 8N1 characters, LSB first
// Assumes the bench clock; a bit lasts BIT cycles
`timescale 1ns/1ps
`default_nettype none
module usc_serial_peer #(
  parameter int BIT = 4
) (
  // Clock
  input  wire logic clk_i,
  // Line, idle high between frames
  output var logic  line_o
);
  import usc_pkg::*;
  initial line_o = 1'b1;
  task automatic send_char(input usc_char_t c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      line_o <= f[i];
      repeat (BIT - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
  endtask
endmodule // usc_serial_peer
`default_nettype wire

// *** verification/usc_status_ctrl_bench.sv ***
// Bench for the serial status and control block
// Assumes a 40 MHz clock and the peer model on the receive line
`timescale 1ns/1ps
`default_nettype none
`include "usc_params.svh"
module usc_status_ctrl_bench;
  logic clk_i, rst_i, cyc, we, ack, txd, oe, txi, rxi, rx, ce;
  logic [4:0] adr;
  logic [31:0] wd, rd, q;
  int miscompares, n_compared, cyc_n, n_tx, n_rx, lo, lo_max;
  logic [68:0] rows[5] = '{{`USC_ADR_STA, 32'hd0ea, 32'hc1f0},
    {`USC_ADR_CTRL, 32'h10003, 32'h10003}, {`USC_ADR_CTRL, 32'h3, 32'h3},
    {5'h10, 32'hffffffff, 32'h0}, {`USC_ADR_STA, 32'h0, 32'h110}};
  // Inversion, infrared, idle level; infrared ends off
  logic [2:0] pol[4] = '{3'b010, 3'b111, 3'b100, 3'b001};
  // Select 11 is reserved and never written
  logic [15:0] tm[3] = '{16'h0400, 16'h2400, 16'h8400};
  int te[3] = '{2, 1, 2};
  logic [7:0] rm[3] = '{8'h00, 8'h80, 8'hc0};
  int re[3] = '{4, 1, 1};
  usc_status_ctrl i_dut (.clk_i, .rst_i, .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rd),
    .wb_ack_o(ack), .serial_tx_o(txd), .serial_tx_oe_o(oe), .serial_rx_i(rx),
    .tx_irq_o(txi), .rx_irq_o(rxi));
  usc_serial_peer #(.BIT(4)) i_peer (.clk_i, .line_o(rx));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Pulse counts and longest low run; a hang ends the run
  always @(posedge clk_i) begin
    n_tx += (txi === 1'b1);
    n_rx += (rxi === 1'b1);
    lo = (txd === 1'b0) ? lo + 1 : 0;
    lo_max = (lo > lo_max) ? lo : lo_max;
    cyc_n++;
    if (cyc_n == 30000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Waits for ack however long it takes; the cycle ceiling ends a hang
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, we, adr, wd} <= {1'b1, w, a, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rd;
    cyc <= 1'b0;
  endtask
  // Polls status until a flag reads v
  task automatic wait_sta(input int b, input logic v);
    do begin
      wb(0, `USC_ADR_STA, 0);
    end while (q[b] !== v);
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    {rst_i, ce, cyc, we, adr, wd} = {2'b11, 39'h0};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("pin owner", 0, oe);
    wb(0, `USC_ADR_STA, 0);
    chk("status reset", 32'h110, q);
    foreach (rows[i]) begin
      wb(1, rows[i][68:64], rows[i][63:32]);
      wb(0, rows[i][68:64], 0);
      chk("register", rows[i][31:0], q);
    end
    $display("test registers done");
    wb(1, `USC_ADR_CTRL, 3);
    foreach (tm[i]) begin
      wb(1, `USC_ADR_STA, tm[i]);
      n_tx = 0;
      wb(1, `USC_ADR_TXD, 8'h55);
      wb(1, `USC_ADR_TXD, 8'ha3);
      wait_sta(8, 1);
      repeat (4) @(posedge clk_i);
      chk("tx irqs", te[i], n_tx);
      chk("pin owner", 1, oe);
    end
    foreach (pol[i]) begin
      wb(1, `USC_ADR_CTRL, {pol[i][1], 16'h3});
      wb(1, `USC_ADR_STA, {pol[i][2], 14'h0400});
      repeat (2) @(posedge clk_i);
      chk("idle level", pol[i][0], txd);
    end
    lo_max = 0;
    wb(1, `USC_ADR_STA, 32'h0c00);
    // Enable low for 8 cycles inside the break stretches the low run by 8
    repeat (10) @(posedge clk_i);
    ce <= 1'b0;
    repeat (8) @(posedge clk_i);
    ce <= 1'b1;
    wait_sta(11, 0);
    repeat (2) @(posedge clk_i);
    chk("break low", 60, lo_max);
    chk("break bit", 0, q[11]);
    repeat (3) wb(1, `USC_ADR_TXD, 8'h0f);
    wb(0, `USC_ADR_STA, 0);
    chk("buffer full", 1, q[9]);
    wb(1, `USC_ADR_STA, 0);
    wb(0, `USC_ADR_STA, 0);
    chk("abort flags", 32'h110, q);
    chk("pin owner", 0, oe);
    $display("test transmit done");
    foreach (rm[i]) begin
      wb(1, `USC_ADR_STA, rm[i]);
      n_rx = 0;
      for (int j = 0; j < 4; j++) i_peer.send_char(8'h30 + j);
      // Last pulse is counted on the edge at which the peer returns
      repeat (2) @(posedge clk_i);
      chk("rx irqs", re[i], n_rx);
      for (int j = 0; j < 4; j++) begin
        wb(0, `USC_ADR_RXD, 0);
        chk("rx data", 32'h30 + j, q);
      end
    end
    for (int j = 0; j < 5; j++) i_peer.send_char(8'h41);
    wb(0, `USC_ADR_STA, 0);
    chk("overrun set", 1, q[1]);
    wb(1, `USC_ADR_STA, 0);
    wb(0, `USC_ADR_STA, 0);
    chk("overrun clear", 0, q[1]);
    $display("test receive done");
    // Reset in mid-run must empty the full receive buffer and clear the flags
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, `USC_ADR_STA, 0);
    chk("status reset", 32'h110, q);
    $display("test reset done");
    end_of_test();
  end
endmodule // usc_status_ctrl_bench
`default_nettype wire
